// file: core/rre_cfg.svh
`ifndef RRE_CFG_SVH
`define RRE_CFG_SVH

`define RRE_PC_W 15
`define RRE_DATA_W 8
`define RRE_FADDR_W 7
`define RRE_IRQ_CTL_W 8
`define RRE_GLOBAL_IRQ_ENABLE_BIT 7
`define RRE_RET_CYCLES 2
`define RRE_DEST_W 1'b0
`define RRE_DEST_F 1'b1
`define RRE_PC_RST 15'h0000
`define RRE_DATA_RST 8'h00
`define RRE_FADDR_RST 7'h00
`endif

// file: core/rre_exec.sv
`include "rre_cfg.svh"
module rre_exec
	import rre_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic req_valid,
	input rre_req_t req,
	output logic req_ready,
	input wire logic [`RRE_PC_W-1:0] stack_top,
	output rre_res_t res
);

	////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// True for the three return forms, which all take a second cycle
	function automatic logic is_return(input rre_op_t op);
		is_return = (op == RRE_OP_INTERRUPT_EXIT) ||
			(op == RRE_OP_SUB_RETURN) ||
			(op == RRE_OP_LITERAL_RETURN);
	endfunction : is_return

	// Rotate left through carry: old carry into bit 0, old bit 7 out
	function automatic logic [`RRE_DATA_W:0] rotl_carry(
		input logic [`RRE_DATA_W-1:0] val,
		input logic cin
	);
		rotl_carry = {val, cin};
	endfunction : rotl_carry

	////////////////////////////////////////////////////////////////////////
	// Sequencing

	typedef enum logic {
		RRE_ST_IDLE,
		RRE_ST_DISCARD
	} rre_state_t;

	// Sequencer state and request qualifiers
	rre_state_t state_ff;
	rre_state_t nxt_state;
	logic take;
	logic take_ret;
	logic take_rot;
	logic [`RRE_DATA_W:0] rot_val;

	// Refuse new work while the second return cycle is running
	assign req_ready = (state_ff == RRE_ST_IDLE);
	assign take = ce && req_valid && req_ready;
	assign take_ret = take && is_return(req.op);
	assign take_rot = take && (req.op == RRE_OP_ROTATE_LEFT_CARRY);
	assign rot_val = rotl_carry(req.fdata, req.carry);

	// Next state: a return holds one extra cycle, rotate runs back to back
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			RRE_ST_IDLE: begin
				if (take_ret) begin
					nxt_state = RRE_ST_DISCARD;
				end
			end
			RRE_ST_DISCARD: begin
				nxt_state = RRE_ST_IDLE;
			end
			default: begin
				nxt_state = RRE_ST_IDLE;
			end
		endcase
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= RRE_ST_IDLE;
		end else if (ce) begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Program counter and stack

	// Return strobes and the captured stack top
	logic pc_load_ff;
	logic [`RRE_PC_W-1:0] pc_ff;
	logic pop_ff;

	// Every return pops once and reloads PC from the sampled stack top
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pc_load_ff <= 1'b0;
			pop_ff <= 1'b0;
			pc_ff <= `RRE_PC_RST;
		end else if (ce) begin
			pc_load_ff <= take_ret;
			pop_ff <= take_ret;
			if (take_ret) begin
				pc_ff <= stack_top;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Working register

	// Working register write strobe and value
	logic w_we_ff;
	logic [`RRE_DATA_W-1:0] w_data_ff;

	// Literal return and rotate to W both write the working register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			w_we_ff <= 1'b0;
			w_data_ff <= `RRE_DATA_RST;
		end else if (ce) begin
			w_we_ff <= 1'b0;
			if (take && req.op == RRE_OP_LITERAL_RETURN) begin
				w_we_ff <= 1'b1;
				w_data_ff <= req.lit;
			end else if (take_rot && req.dest == `RRE_DEST_W) begin
				w_we_ff <= 1'b1;
				w_data_ff <= rot_val[`RRE_DATA_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// File register write-back

	// File write strobe, address and value
	logic f_we_ff;
	logic [`RRE_FADDR_W-1:0] f_addr_ff;
	logic [`RRE_DATA_W-1:0] f_data_ff;

	// Rotate with destination one writes back to its source address
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			f_we_ff <= 1'b0;
			f_addr_ff <= `RRE_FADDR_RST;
			f_data_ff <= `RRE_DATA_RST;
		end else if (ce) begin
			f_we_ff <= take_rot && (req.dest == `RRE_DEST_F);
			if (take_rot) begin
				f_addr_ff <= req.faddr;
				f_data_ff <= rot_val[`RRE_DATA_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Carry flag

	// Carry write strobe and new carry
	logic c_we_ff;
	logic c_data_ff;

	// Only the rotate touches carry; returns never drive a status write
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			c_we_ff <= 1'b0;
			c_data_ff <= 1'b0;
		end else if (ce) begin
			c_we_ff <= take_rot;
			if (take_rot) begin
				c_data_ff <= rot_val[`RRE_DATA_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt control

	// One-cycle set request for the global enable
	logic global_irq_enable_set_ff;

	// Set pulse only; the control register owner ORs it in, so no clear race
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			global_irq_enable_set_ff <= 1'b0;
		end else if (ce) begin
			global_irq_enable_set_ff <= take && (req.op == RRE_OP_INTERRUPT_EXIT);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Prefetch discard

	// Flush strobe toward the fetch stage
	logic discard_ff;

	// Word fetched during the return is stale; flush it in the second cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			discard_ff <= 1'b0;
		end else if (ce) begin
			discard_ff <= take_ret;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output bundle

	// All data fields come straight from flip-flops
	always_comb begin
		res = '0;
		res.pc_load = pc_load_ff;
		res.pc = pc_ff;
		res.pop = pop_ff;
		res.w_we = w_we_ff;
		res.w_data = w_data_ff;
		res.f_we = f_we_ff;
		res.f_addr = f_addr_ff;
		res.f_data = f_data_ff;
		res.c_we = c_we_ff;
		res.c_data = c_data_ff;
		res.irq_set = '0;
		res.irq_set[`RRE_GLOBAL_IRQ_ENABLE_BIT] = global_irq_enable_set_ff;
		res.discard = discard_ff;
	end

endmodule : rre_exec

// file: core/rre_pkg.sv
`include "rre_cfg.svh"
package rre_pkg;
	// Instruction class handed over by the decoder
	typedef enum logic [2:0] {
		RRE_OP_NONE,
		RRE_OP_INTERRUPT_EXIT,
		RRE_OP_SUB_RETURN,
		RRE_OP_LITERAL_RETURN,
		RRE_OP_ROTATE_LEFT_CARRY
	} rre_op_t;

	// One decoded request with its operands
	typedef struct packed {
		rre_op_t op;
		logic [`RRE_DATA_W-1:0] lit;
		logic [`RRE_FADDR_W-1:0] faddr;
		logic dest;
		logic [`RRE_DATA_W-1:0] fdata;
		logic carry;
	} rre_req_t;

	// Update strobes toward PC, stack, W, file, carry and interrupt control
	typedef struct packed {
		logic pc_load;
		logic [`RRE_PC_W-1:0] pc;
		logic pop;
		logic w_we;
		logic [`RRE_DATA_W-1:0] w_data;
		logic f_we;
		logic [`RRE_FADDR_W-1:0] f_addr;
		logic [`RRE_DATA_W-1:0] f_data;
		logic c_we;
		logic c_data;
		logic [`RRE_IRQ_CTL_W-1:0] irq_set;
		logic discard;
	} rre_res_t;
endpackage : rre_pkg

// file: dv/rre_exec_checker.sv
`include "rre_cfg.svh"
module rre_exec_checker
	import rre_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic ce,
	input wire logic req_valid,
	input rre_req_t req,
	input wire logic req_ready,
	input wire logic [`RRE_PC_W-1:0] stack_top,
	input rre_res_t res
);
	logic tk;
	logic ret;
	// Taken request and return class
	assign tk = ce & req_valid & req_ready;
	assign ret = req.op inside {RRE_OP_INTERRUPT_EXIT, RRE_OP_SUB_RETURN, RRE_OP_LITERAL_RETURN};
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	////////////////////////////////////////////////////////////////
	property p_ie_pc;
		tk && req.op == RRE_OP_INTERRUPT_EXIT |=> res.pop && res.pc_load && res.pc == $past(stack_top);
	endproperty
	a_ie_pc: assert property (p_ie_pc) else $error("exit pc bad");
	property p_ie_gie;
		tk && req.op == RRE_OP_INTERRUPT_EXIT |=> res.irq_set == 8'h80;
	endproperty
	a_ie_gie: assert property (p_ie_gie) else $error("enable set bad");
	property p_ret_2c;
		tk && ret |=> !req_ready && res.discard ##1 req_ready && !res.pc_load;
	endproperty
	a_ret_2c: assert property (p_ret_2c) else $error("return length bad");
	property p_sub;
		tk && req.op == RRE_OP_SUB_RETURN |=> res.pop && res.pc == $past(stack_top)
			&& !res.w_we && res.irq_set == 8'h00;
	endproperty
	a_sub: assert property (p_sub) else $error("sub return bad");
	property p_lit;
		tk && req.op == RRE_OP_LITERAL_RETURN |=> res.w_we && res.w_data == $past(req.lit);
	endproperty
	a_lit: assert property (p_lit) else $error("literal bad");
	property p_lit_pc;
		tk && req.op == RRE_OP_LITERAL_RETURN |=> res.pc_load && res.pc == $past(stack_top);
	endproperty
	a_lit_pc: assert property (p_lit_pc) else $error("literal pc bad");
	property p_rot;
		tk && req.op == RRE_OP_ROTATE_LEFT_CARRY |=> res.c_we && req_ready && !res.pc_load
			&& res.c_data == $past(req.fdata[7]);
	endproperty
	a_rot: assert property (p_rot) else $error("rotate carry bad");
	property p_dst;
		tk && req.op == RRE_OP_ROTATE_LEFT_CARRY |=> res.f_we == $past(req.dest)
			&& res.w_we != $past(req.dest);
	endproperty
	a_dst: assert property (p_dst) else $error("rotate dest bad");
	property p_ret_nc;
		tk && ret |=> !res.c_we;
	endproperty
	a_ret_nc: assert property (p_ret_nc) else $error("return hit carry");
endmodule : rre_exec_checker
bind rre_exec rre_exec_checker u_chk (.clk(clk), .resetn(resetn), .ce(ce), .req_valid(req_valid),
	.req(req), .req_ready(req_ready), .stack_top(stack_top), .res(res));

// file: dv/rre_exec_tb.sv
`include "rre_cfg.svh"
module rre_exec_tb
	import rre_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0;
	logic resetn = 0;
	logic ce = 1;
	logic req_valid = 0;
	rre_req_t req = '0;
	logic req_ready;
	logic [`RRE_PC_W-1:0] stack_top = '0;
	rre_res_t res;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	int seed = 15;
	rre_exec uut (.clk(clk), .resetn(resetn), .ce(ce), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .stack_top(stack_top), .res(res));
	always #2.5 clk = ~clk;
	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rot(input logic [7:0] v, input logic c);
		return {v[6:0], c};
	endfunction : rot
	task chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask : chk
	task summarize;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// One request, driven at the falling edge; valid held so rotates run back to back
	task do_op(input rre_op_t op, input logic [7:0] lit, input logic [7:0] fd,
		input logic [6:0] fa, input logic d, input logic c, input logic [14:0] st);
		req = '{op: op, lit: lit, faddr: fa, dest: d, fdata: fd, carry: c};
		stack_top = st;
		req_valid = 1;
		@(negedge clk);
		if (op == RRE_OP_ROTATE_LEFT_CARRY) begin
			chk(res.c_we, 1);
			chk(res.c_data, fd[7]);
			chk({res.w_we, res.f_we}, {!d, d});
			chk(d ? {res.f_addr, res.f_data} : res.w_data, d ? {fa, rot(fd, c)} : rot(fd, c));
			chk(res.pc_load, 0);
		end else if (op == RRE_OP_NONE) begin
			chk({res.pc_load, res.w_we, res.f_we, res.c_we}, 0);
		end else begin
			chk({res.pc_load, res.pop, res.pc}, {2'b11, st});
			chk(res.irq_set, op == RRE_OP_INTERRUPT_EXIT ? 8'h80 : 8'h00);
			chk({res.w_we, res.c_we, res.discard}, {op == RRE_OP_LITERAL_RETURN, 2'b01});
			if (op == RRE_OP_LITERAL_RETURN) chk(res.w_data, lit);
			chk(req_ready, 0);
			req_valid = 0;
			@(negedge clk);
			chk({req_ready, res.pc_load}, 2'b10);
		end
	endtask : do_op
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc > 3000) begin
			err_total++;
			summarize();
		end
	end
	initial begin
		repeat (3) @(negedge clk);
		resetn = 1;
		chk({req_ready, res}, {1'b1, 53'h0});
		// Corners: every return with extreme operands, then documented rotate case
		for (int i = 1; i < 4; i++) do_op(rre_op_t'(i), 8'hff, 8'h00, 7'h00, 0, 0, 15'h7fff);
		do_op(RRE_OP_LITERAL_RETURN, 8'h00, 8'h00, 7'h00, 0, 1, 15'h0000);
		do_op(RRE_OP_ROTATE_LEFT_CARRY, 8'h00, 8'he6, 7'h7f, 0, 0, 15'h0000);
		do_op(RRE_OP_ROTATE_LEFT_CARRY, 8'h00, 8'h80, 7'h7f, 1, 1, 15'h0000);
		// Clock enable low: a pending exit is not taken and the last rotate's c_we, f_we and f_data hold
		do_op(RRE_OP_ROTATE_LEFT_CARRY, 8'h00, 8'h5a, 7'h11, 1, 0, 15'h0000);
		ce = 0;
		req = '{op: RRE_OP_INTERRUPT_EXIT, lit: 8'h3c, faddr: 7'h00, dest: 0, fdata: 8'h00, carry: 0};
		stack_top = 15'h1234;
		repeat (2) @(negedge clk);
		chk({req_ready, res.c_we, res.f_we, res.f_data, res.pc_load, res.discard},
			{3'b111, rot(8'h5a, 1'b0), 2'b00});
		ce = 1;
		do_op(RRE_OP_INTERRUPT_EXIT, 8'h3c, 8'h00, 7'h00, 0, 0, 15'h1234);
		repeat (300) do_op(rre_op_t'($unsigned($random(seed)) % 5), $random(seed), $random(seed),
			$random(seed), $random(seed), $random(seed), $random(seed));
		req_valid = 0;
		summarize();
	end
endmodule : rre_exec_tb
